// *** wss_params.svh ***
// Purpose: Constants of the weld schedule sequencer
// Assumes: Included by bare name
// Notes:   Field macros are part-selects of 32-bit words
`ifndef WSS_PARAMS_SVH
`define WSS_PARAMS_SVH
// ==================================================
// Register map
`define WSS_ADDR_CTRL   12'h000
`define WSS_ADDR_STATUS 12'h004
`define WSS_PA_REGION   11:10
`define WSS_MEM_REGION  2'h1
`define WSS_PA_SCHED    9:4
`define WSS_PA_WORD     3:2
`define WSS_CTRL_RST    32'h0000_0000
// ==================================================
// Control and status fields
`define WSS_C_BASE      5:0
`define WSS_C_SEAM      15:8
`define WSS_C_RUN       16
`define WSS_S_STATE     2:0
`define WSS_S_FIRE      3
`define WSS_S_VALVE     6:4
`define WSS_S_SCHED     13:8
`define WSS_S_FLASH     14
`define WSS_S_INIT      15
`define WSS_S_LEVEL     23:16
// ==================================================
// Schedule words 0, 1, 2
`define WSS_F_SQZ       7:0
`define WSS_F_WELD      15:8
`define WSS_F_PCT       23:16
`define WSS_F_HOLD      31:24
`define WSS_F_OFF       7:0
`define WSS_F_IMP       15:8
`define WSS_F_COOL      23:16
`define WSS_F_VALVE     26:24
`define WSS_F_CYC       7:0
`define WSS_F_SLM       15:8
`define WSS_F_SLC       23:16
// ==================================================
// Codes
`define WSS_CM_REPEAT   8'h01
`define WSS_CM_CHAIN    8'h02
`define WSS_CM_SUCC     8'h03
`define WSS_SL_UP       8'h01
`define WSS_SL_DOWN     8'h02
`endif

// *** wss_pkg.sv ***
// Purpose: Types of the weld schedule sequencer
// Assumes: Nothing
// Notes:   Gray codes along squeeze, weld, cool, hold, off
package wss_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SQZ  = 3'h1,
		ST_WELD = 3'h3,
		ST_COOL = 3'h2,
		ST_HOLD = 3'h6,
		ST_OFF  = 3'h7,
		ST_WAIT = 3'h5
	} wss_state_e;
endpackage : wss_pkg

// *** wss_sync.sv ***
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk
// Notes:   Only the second stage is visible
`timescale 1ns/1ps
module wss_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : wss_sync

// *** wss_ramp.sv ***
// Purpose: Linear current ramp between two percent levels
// Assumes: total counts line cycles of the slope
// Notes:   Ends at stop once elapsed reaches total
`timescale 1ns/1ps
module wss_ramp #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] start,
	input  wire logic [W-1:0] stop,
	input  wire logic [W-1:0] total,
	input  wire logic [W-1:0] elapsed,
	output logic      [W-1:0] level
);
	logic signed [W:0]     diff;
	logic signed [2*W+1:0] prod;
	logic signed [2*W+1:0] den;
	logic signed [2*W+1:0] quo;

	always_comb begin
		diff = $signed({1'b0, stop}) - $signed({1'b0, start});
		prod = diff * $signed({1'b0, elapsed});
		den  = (total == '0) ? (2*W+2)'(1) : $signed({{(W+2){1'b0}}, total});
		quo  = prod / den;
		if (total == '0 || elapsed >= total) begin
			level = stop;
		end else begin
			level = W'($signed({{(W+2){1'b0}}, start}) + quo);
		end
	end
endmodule : wss_ramp

// *** wss_sequencer.sv ***
// Purpose: Weld schedule sequencer with APB schedule storage
// Assumes: Line sync and initiation pins asynchronous; line tick per mains cycle
// Notes:   Schedules are three words each; counts are line cycles
//
// How it works
// R1: Successive: flash next, await initiation, return
// R2: Chained schedules advance and update display
// R3: Upslope ramps from preceding percent current
// R4: Downslope ramps to following schedule percent
// R5: Hold quenches, next weld tempers
// R6: Indicator shows current and amplitude
// R7: Chain valves release together at end
// R8: Three valves, selectable per schedule
// R9: Forge valve added by second schedule
// R10: Zero hold/squeeze keeps current continuous
// R11: Forge after weld delayed by hold/squeeze
// R12: Each schedule uses its own percent
// R13: Continuous seam fires while initiation held
// R14: Seam with cool alternates heat, cool
// R15: Seam setting zero gives spot operation
// R16: Repeat restarts while initiation stays held
// R17: Valve field is a three-bit mask
// R18: Phases count line cycles, zero skips
// R19: Chained cycle mode continues, else ends
`timescale 1ns/1ps
`include "wss_params.svh"
module wss_sequencer #(
	parameter int NSCHED = 64
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        line_sync_in,
	input  wire logic        first_stage_initiation_input,
	output logic      [2:0]  valve_out,
	output logic             weld_fire,
	output logic      [7:0]  weld_indicator,
	output logic      [5:0]  sched_display,
	output logic             display_flash
);
	localparam int SW = $clog2(NSCHED);

	// ==================================================
	// Pins
	logic [1:0] pins_s;
	logic       line_s;
	logic       init_s;
	logic       line_p_q;
	logic       tick;

	wss_sync #(.W(2)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({line_sync_in, first_stage_initiation_input}),
		.q     (pins_s)
	);
	assign line_s = pins_s[1];
	assign init_s = pins_s[0];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			line_p_q <= 1'b0;
		end else begin
			line_p_q <= line_s;
		end
	end
	// R18: one tick per line cycle
	assign tick = line_s & ~line_p_q;

	// ==================================================
	// Registers and schedule memory
	logic [31:0]      ctrl_q;
	logic [31:0]      mem_q [NSCHED][3];
	logic [31:0]      rd_c;
	logic [31:0]      prdata_q;
	logic             pready_q;
	logic             pslverr_q;
	logic             acc;
	logic             wr;
	logic             is_ctrl;
	logic             is_stat;
	logic             is_mem;
	logic [5:0]       pa_sched;
	logic [1:0]       pa_word;
	logic             hit;
	logic [31:0]      status_c;

	wss_pkg::wss_state_e state_q;
	wss_pkg::wss_state_e state_d;
	logic [7:0]       cnt_q;
	logic [7:0]       cnt_d;
	logic             ld_q;
	logic             ld_d;
	logic [SW-1:0]    sched_q;
	logic [SW-1:0]    sched_d;
	logic [SW-1:0]    sched_nx;
	logic [7:0]       imp_q;
	logic [7:0]       imp_d;
	logic [7:0]       el_q;
	logic [7:0]       el_d;
	logic [7:0]       prev_q;
	logic [7:0]       prev_d;
	logic             succ_q;
	logic             succ_d;
	logic             armed_q;
	logic [2:0]       valve_q;
	logic             seen_q;
	logic             fire_q;
	logic             fire_d;
	logic [7:0]       ind_q;
	logic [7:0]       level_c;
	logic [7:0]       ramp_lo;
	logic [7:0]       ramp_hi;
	logic [7:0]       ramp_lv;
	logic [7:0]       dur_c;
	logic [7:0]       wlen;

	assign pa_sched = paddr[`WSS_PA_SCHED];
	assign pa_word  = paddr[`WSS_PA_WORD];
	assign is_ctrl  = (paddr == `WSS_ADDR_CTRL);
	assign is_stat  = (paddr == `WSS_ADDR_STATUS);
	assign is_mem   = (paddr[`WSS_PA_REGION] == `WSS_MEM_REGION) && (int'(pa_sched) < NSCHED);
	assign hit      = is_ctrl | is_stat | is_mem;
	assign acc      = psel & penable & ~pready_q;
	assign wr       = psel & penable & pready_q & pwrite;

	always_comb begin
		status_c = '0;
		status_c[`WSS_S_STATE] = state_q;
		status_c[`WSS_S_FIRE]  = fire_q;
		status_c[`WSS_S_VALVE] = valve_q;
		status_c[`WSS_S_SCHED] = 6'(sched_q);
		status_c[`WSS_S_FLASH] = (state_q == wss_pkg::ST_WAIT);
		status_c[`WSS_S_INIT]  = init_s;
		status_c[`WSS_S_LEVEL] = ind_q;
		rd_c = '0;
		if (is_ctrl) begin
			rd_c = ctrl_q;
		end else if (is_stat) begin
			rd_c = status_c;
		end else if (is_mem && pa_word != 2'h3) begin
			rd_c = mem_q[pa_sched][pa_word];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= acc;
			if (acc) begin
				prdata_q  <= rd_c;
				pslverr_q <= ~hit;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= `WSS_CTRL_RST;
		end else if (wr && is_ctrl) begin
			ctrl_q <= pwdata;
		end
	end

	always_ff @(posedge clk) begin
		if (wr && is_mem && pa_word != 2'h3) begin
			mem_q[pa_sched][pa_word] <= pwdata;
		end
	end

	// ==================================================
	// Current schedule fields
	logic [31:0] w0;
	logic [31:0] w1;
	logic [31:0] w2;
	logic [7:0]  pct_nx;
	logic        seam;
	logic        run;
	logic [SW-1:0] base;
	logic        chain_end;

	assign w0       = mem_q[sched_q][0];
	assign w1       = mem_q[sched_q][1];
	assign w2       = mem_q[sched_q][2];
	assign sched_nx = sched_q + SW'(1);
	assign pct_nx   = mem_q[sched_nx][0][`WSS_F_PCT];
	// R15: zero seam setting means spot
	assign seam     = (ctrl_q[`WSS_C_SEAM] != 8'h00);
	assign run      = ctrl_q[`WSS_C_RUN];
	assign base     = SW'(ctrl_q[`WSS_C_BASE]);
	// R19: non-chained hold end closes the chain
	assign chain_end = (state_q == wss_pkg::ST_HOLD) && !ld_q && (cnt_q == 8'h00)
		&& (w2[`WSS_F_CYC] != `WSS_CM_CHAIN);

	// Slope phase lasts the longer of weld and slope count
	assign wlen = (w2[`WSS_F_SLM] != 8'h00 && w2[`WSS_F_SLC] > w0[`WSS_F_WELD])
		? w2[`WSS_F_SLC] : w0[`WSS_F_WELD];

	always_comb begin
		unique case (state_q)
			wss_pkg::ST_SQZ:  dur_c = w0[`WSS_F_SQZ];
			wss_pkg::ST_WELD: dur_c = wlen;
			wss_pkg::ST_COOL: dur_c = w1[`WSS_F_COOL];
			wss_pkg::ST_HOLD: dur_c = w0[`WSS_F_HOLD];
			wss_pkg::ST_OFF:  dur_c = w1[`WSS_F_OFF];
			default:          dur_c = 8'h00;
		endcase
	end

	// ==================================================
	// Sequencer
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		ld_d    = 1'b0;
		sched_d = sched_q;
		imp_d   = imp_q;
		el_d    = el_q;
		prev_d  = prev_q;
		succ_d  = succ_q;
		// R18: count down on line cycles
		if (tick && cnt_q != 8'h00 && !ld_q) begin
			cnt_d = cnt_q - 8'h01;
		end
		if (tick && state_q == wss_pkg::ST_WELD && el_q != 8'hFF) begin
			el_d = el_q + 8'h01;
		end
		if (ld_q) begin
			cnt_d = dur_c;
			if (state_q == wss_pkg::ST_SQZ) begin
				imp_d = (w1[`WSS_F_IMP] == 8'h00) ? 8'h01 : w1[`WSS_F_IMP];
				el_d  = 8'h00;
			end
		end else if (cnt_q == 8'h00) begin
			unique case (state_q)
				wss_pkg::ST_IDLE: begin
					sched_d = base;
					succ_d  = 1'b0;
					if (run && init_s && armed_q) begin
						state_d = wss_pkg::ST_SQZ;
						ld_d    = 1'b1;
					end
				end
				wss_pkg::ST_SQZ: begin
					state_d = wss_pkg::ST_WELD;
					ld_d    = 1'b1;
				end
				wss_pkg::ST_WELD: begin
					ld_d = 1'b1;
					if (seam) begin
						// R13: continuous while held
						// R14: cool time gives intermittent seam
						if (!init_s) begin
							state_d = wss_pkg::ST_HOLD;
						end else if (w1[`WSS_F_COOL] != 8'h00) begin
							state_d = wss_pkg::ST_COOL;
						end
					end else if (imp_q > 8'h01) begin
						imp_d   = imp_q - 8'h01;
						state_d = wss_pkg::ST_COOL;
					end else begin
						state_d = wss_pkg::ST_HOLD;
					end
				end
				wss_pkg::ST_COOL: begin
					ld_d    = 1'b1;
					state_d = (seam && !init_s) ? wss_pkg::ST_HOLD : wss_pkg::ST_WELD;
				end
				wss_pkg::ST_HOLD: begin
					if (w2[`WSS_F_CYC] == `WSS_CM_CHAIN) begin
						// R2: chained advance without initiation
						// R5: hold of first acts as quench
						prev_d  = w0[`WSS_F_PCT];
						sched_d = sched_nx;
						state_d = wss_pkg::ST_SQZ;
						ld_d    = 1'b1;
					end else if (succ_q) begin
						// R1: second of pair returns to first
						succ_d  = 1'b0;
						sched_d = base;
						state_d = wss_pkg::ST_IDLE;
					end else if (w2[`WSS_F_CYC] == `WSS_CM_SUCC) begin
						// R1: flash next, wait new initiation
						succ_d  = 1'b1;
						sched_d = sched_nx;
						state_d = wss_pkg::ST_WAIT;
					end else if (w2[`WSS_F_CYC] == `WSS_CM_REPEAT) begin
						state_d = wss_pkg::ST_OFF;
						ld_d    = 1'b1;
					end else begin
						state_d = wss_pkg::ST_IDLE;
					end
				end
				wss_pkg::ST_OFF: begin
					// R16: held initiation restarts
					if (run && init_s) begin
						state_d = wss_pkg::ST_SQZ;
						ld_d    = 1'b1;
					end else begin
						state_d = wss_pkg::ST_IDLE;
					end
				end
				wss_pkg::ST_WAIT: begin
					if (!run) begin
						state_d = wss_pkg::ST_IDLE;
					end else if (init_s && armed_q) begin
						state_d = wss_pkg::ST_SQZ;
						ld_d    = 1'b1;
					end
				end
				default: begin
					state_d = wss_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= wss_pkg::ST_IDLE;
			cnt_q   <= 8'h00;
			ld_q    <= 1'b0;
			sched_q <= '0;
			imp_q   <= 8'h00;
			el_q    <= 8'h00;
			prev_q  <= 8'h00;
			succ_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			ld_q    <= ld_d;
			sched_q <= sched_d;
			imp_q   <= imp_d;
			el_q    <= el_d;
			prev_q  <= prev_d;
			succ_q  <= succ_d;
		end
	end

	// R16: momentary initiation runs one sequence
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			armed_q <= 1'b0;
		end else if (!init_s) begin
			armed_q <= 1'b1;
		end else if ((state_q == wss_pkg::ST_IDLE || state_q == wss_pkg::ST_WAIT)
			&& state_d == wss_pkg::ST_SQZ) begin
			armed_q <= 1'b0;
		end
	end

	// ==================================================
	// Valves
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			valve_q <= 3'h0;
		// R7: release all valves together
		end else if (chain_end || state_q == wss_pkg::ST_IDLE) begin
			valve_q <= 3'h0;
		// R8: per-schedule valve, bitmask
		// R17: bit n drives valve n+1
		end else if (state_q == wss_pkg::ST_SQZ && ld_q && !seen_q) begin
			valve_q <= valve_q | w1[`WSS_F_VALVE];
		// R9: forge valve joins after first weld
		// R11: delayed by hold or squeeze
		end else if (state_q == wss_pkg::ST_SQZ && !ld_q && cnt_q == 8'h00 && seen_q) begin
			valve_q <= valve_q | w1[`WSS_F_VALVE];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seen_q <= 1'b0;
		end else if (chain_end || state_q == wss_pkg::ST_IDLE) begin
			seen_q <= 1'b0;
		end else if (fire_q) begin
			seen_q <= 1'b1;
		end
	end

	// ==================================================
	// Current
	// R3: upslope from preceding percent
	// R4: downslope to following percent
	assign ramp_lo = (w2[`WSS_F_SLM] == `WSS_SL_UP) ? prev_q : w0[`WSS_F_PCT];
	assign ramp_hi = (w2[`WSS_F_SLM] == `WSS_SL_UP) ? w0[`WSS_F_PCT] : pct_nx;

	wss_ramp #(.W(8)) u_ramp (
		.start   (ramp_lo),
		.stop    (ramp_hi),
		.total   (w2[`WSS_F_SLC]),
		.elapsed (el_q),
		.level   (ramp_lv)
	);

	// R12: own percent per schedule
	assign level_c = (w2[`WSS_F_SLM] == `WSS_SL_UP || w2[`WSS_F_SLM] == `WSS_SL_DOWN)
		? ramp_lv : w0[`WSS_F_PCT];

	// R10: zero-length phases keep firing
	always_comb begin
		fire_d = (state_q == wss_pkg::ST_WELD) && !ld_q && (cnt_q != 8'h00 || (seam && init_s));
		fire_d = fire_d || (fire_q && (ld_q || cnt_q == 8'h00)
			&& state_q != wss_pkg::ST_IDLE && state_q != wss_pkg::ST_WAIT);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fire_q <= 1'b0;
			ind_q  <= 8'h00;
		end else begin
			fire_q <= fire_d;
			// R6: indicator carries the amplitude
			ind_q  <= fire_d ? level_c : 8'h00;
		end
	end

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign valve_out      = valve_q;
	assign weld_fire      = fire_q;
	assign weld_indicator = ind_q;
	assign sched_display  = 6'(sched_q);
	assign display_flash  = (state_q == wss_pkg::ST_WAIT);

	// ==================================================
	// Assertions
	property p_chain;
		@(posedge clk) disable iff (!rst_n)
		(state_q == wss_pkg::ST_HOLD && !ld_q && cnt_q == 8'h00
			&& w2[`WSS_F_CYC] == `WSS_CM_CHAIN)
		|=> state_q == wss_pkg::ST_SQZ && sched_q == $past(sched_nx) ##1 ld_q == 1'b0;
	endproperty
	a_chain: assert property (p_chain) else $error("chain did not advance"); // R2

	property p_succ;
		@(posedge clk) disable iff (!rst_n)
		(chain_end && !succ_q && w2[`WSS_F_CYC] == `WSS_CM_SUCC)
		|=> display_flash && succ_q && sched_display == 6'($past(sched_nx));
	endproperty
	a_succ: assert property (p_succ) else $error("successive wait missing"); // R1

	property p_ret;
		@(posedge clk) disable iff (!rst_n)
		(chain_end && succ_q) |=> state_q == wss_pkg::ST_IDLE && sched_q == $past(base);
	endproperty
	a_ret: assert property (p_ret) else $error("no return to first"); // R1

	property p_release;
		@(posedge clk) disable iff (!rst_n)
		chain_end |=> valve_out == 3'h0;
	endproperty
	a_release: assert property (p_release) else $error("valves not released"); // R7

	property p_mask;
		@(posedge clk) disable iff (!rst_n)
		(state_q == wss_pkg::ST_SQZ && ld_q && !seen_q && !chain_end)
		|=> (valve_out & $past(w1[`WSS_F_VALVE])) == $past(w1[`WSS_F_VALVE]);
	endproperty
	a_mask: assert property (p_mask) else $error("valve mask not applied"); // R17

	property p_ind;
		@(posedge clk) disable iff (!rst_n)
		(state_q == wss_pkg::ST_WELD && !ld_q && cnt_q != 8'h00 && w2[`WSS_F_SLM] == 8'h00)
		|=> weld_fire && weld_indicator == $past(w0[`WSS_F_PCT]);
	endproperty
	a_ind: assert property (p_ind) else $error("indicator wrong"); // R6

	property p_seam;
		@(posedge clk) disable iff (!rst_n)
		(state_q == wss_pkg::ST_WELD && !ld_q && cnt_q == 8'h00 && seam && init_s
			&& w1[`WSS_F_COOL] == 8'h00) |=> state_q == wss_pkg::ST_WELD ##1 weld_fire;
	endproperty
	a_seam: assert property (p_seam) else $error("seam current dropped"); // R13

	property p_skip;
		@(posedge clk) disable iff (!rst_n)
		(state_q == wss_pkg::ST_SQZ && ld_q && w0[`WSS_F_SQZ] == 8'h00)
		|=> ##1 state_q == wss_pkg::ST_WELD;
	endproperty
	a_skip: assert property (p_skip) else $error("zero phase not skipped"); // R18

	property p_spot;
		@(posedge clk) disable iff (!rst_n)
		(!seam && state_q == wss_pkg::ST_WELD && !ld_q && cnt_q == 8'h00 && imp_q <= 8'h01)
		|=> state_q == wss_pkg::ST_HOLD;
	endproperty
	a_spot: assert property (p_spot) else $error("spot weld did not hold"); // R15

	property p_rep;
		@(posedge clk) disable iff (!rst_n)
		(state_q == wss_pkg::ST_OFF && !ld_q && cnt_q == 8'h00 && run && init_s)
		|=> state_q == wss_pkg::ST_SQZ;
	endproperty
	a_rep: assert property (p_rep) else $error("repeat did not restart"); // R16

	property p_cv_chain;
		@(posedge clk) disable iff (!rst_n) chain_end && sched_q != base;
	endproperty
	c_cv_chain: cover property (p_cv_chain);

	property p_cv_wait;
		@(posedge clk) disable iff (!rst_n) $rose(display_flash);
	endproperty
	c_cv_wait: cover property (p_cv_wait);

	property p_cv_cool;
		@(posedge clk) disable iff (!rst_n) seam && state_q == wss_pkg::ST_COOL;
	endproperty
	c_cv_cool: cover property (p_cv_cool);
endmodule : wss_sequencer

// *** wss_plant.sv ***
// Purpose: Mains, contactor and valve stand-in for the sequencer
// Assumes: Mains half period counted in clk cycles
// Notes:   Counts fire pulses, line ticks while firing, valves seen
`timescale 1ns/1ps
module wss_plant #(
	parameter int HALF = 20
) (
	input  wire logic       clk,
	input  wire logic       clr,
	input  wire logic       weld_fire,
	input  wire logic [2:0] valve_out,
	output logic            line_sync_in,
	output logic      [7:0] fire_ticks,
	output logic      [7:0] fire_pulses,
	output logic      [2:0] valve_or
);
	int   cnt;
	logic fire_prev;
	// ==================================================
	// Free-running mains wave
	initial begin
		cnt = 0;
		line_sync_in = 1'b0;
		fire_prev = 1'b0;
	end
	always @(posedge clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) begin
			line_sync_in <= ~line_sync_in;
		end
	end
	// ==================================================
	// Contactor and valve watch
	always @(posedge clk) begin
		fire_prev <= weld_fire;
		if (clr) begin
			fire_ticks  <= 8'h00;
			fire_pulses <= 8'h00;
			valve_or    <= 3'h0;
		end else begin
			if (cnt == HALF - 1 && !line_sync_in && weld_fire) begin
				fire_ticks <= fire_ticks + 8'h01;
			end
			if (weld_fire && !fire_prev) begin
				fire_pulses <= fire_pulses + 8'h01;
			end
			valve_or <= valve_or | valve_out;
		end
	end
endmodule : wss_plant

// *** wss_sequencer_tb.sv ***
// Purpose: Self-checking bench of the weld schedule sequencer
// Assumes: Mains period of 40 clk cycles
// Notes:   Progress is followed by polling the status word
`timescale 1ns/1ps
`include "wss_params.svh"
module wss_sequencer_tb;
	logic        clk         = 1'b0;
	logic        rst_n       = 1'b0;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [11:0] paddr       = 12'h000;
	logic [31:0] pwdata      = 32'h0000_0000;
	logic        init        = 1'b0;
	logic        clr         = 1'b1;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        er;
	logic        line;
	logic        fire;
	logic [2:0]  valve_out;
	logic [7:0]  level;
	logic [5:0]  disp;
	logic        flash;
	logic [7:0]  ticks;
	logic [7:0]  pulses;
	logic [2:0]  vor;
	int          miscompares = 0;
	int          num_checks  = 0;

	always #2.5 clk = ~clk;

	wss_sequencer wss_sequencer_i (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .line_sync_in(line),
		.first_stage_initiation_input(init), .valve_out(valve_out),
		.weld_fire(fire), .weld_indicator(level), .sched_display(disp),
		.display_flash(flash));
	wss_plant wss_plant_i (.clk(clk), .clr(clr), .weld_fire(fire),
		.valve_out(valve_out), .line_sync_in(line), .fire_ticks(ticks),
		.fire_pulses(pulses), .valve_or(vor));
	// ==================================================
	// Shared tasks
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
		num_checks++;
		if (got < lo || got > hi || $isunknown(got)) begin
			miscompares++;
			$display("unexpected at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_rng

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic ws(input logic [5:0] s, input logic [7:0] sq, wd, pc, hd, cl,
		input logic [2:0] vm, input logic [7:0] cy);
		logic [11:0] a;
		a = {2'h1, s, 4'h0};
		apb(1'b1, a, {hd, pc, wd, sq}, rd, er);
		apb(1'b1, a + 12'h004, {5'h00, vm, cl, 8'h01, 8'h01}, rd, er);
		apb(1'b1, a + 12'h008, {24'h00_0000, cy}, rd, er);
	endtask : ws

	task automatic wait_state(input logic [3:0] st);
		int n;
		n = 0;
		do begin
			apb(1'b0, `WSS_ADDR_STATUS, 32'h0000_0000, rd, er);
			n++;
		end while (rd[3:0] !== st && n < 1000);
		chk_rng(n, 1, 999);
	endtask : wait_state

	task automatic start(input logic [31:0] c);
		apb(1'b1, `WSS_ADDR_CTRL, c, rd, er);
		clr  <= 1'b1;
		init <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask : start

	task automatic hold_rel(input int n, input logic [2:0] st);
		repeat (n) @(posedge clk);
		init <= 1'b0;
		wait_state(st);
	endtask : hold_rel
	// ==================================================
	// Scenarios
	task automatic t_regs();
		apb(1'b1, `WSS_ADDR_CTRL, 32'h0000_0105, rd, er);
		apb(1'b0, `WSS_ADDR_CTRL, 32'h0000_0000, rd, er);
		chk(rd, 32'h0000_0105);
		apb(1'b0, `WSS_ADDR_STATUS, 32'h0000_0000, rd, er);
		chk(rd, 32'h0000_0500);
		apb(1'b0, 12'h800, 32'h0000_0000, rd, er);
		chk({31'h0, er}, 32'h0000_0001);
		ws(6'h00, 8'h02, 8'h03, 8'h28, 8'h02, 8'h00, 3'h5, 8'h00);
		apb(1'b0, 12'h400, 32'h0000_0000, rd, er);
		chk(rd, 32'h0228_0302);
		apb(1'b0, 12'h40C, 32'h0000_0000, rd, er);
		chk(rd, 32'h0000_0000);
	endtask : t_regs

	task automatic t_spot();
		start(32'h0001_0000);
		wait_state(4'hB);
		chk({rd[23:16], 1'b0, rd[6:3]}, {8'h28, 1'b0, 3'h5, 1'b1});
		chk(level, 32'h0000_0028);
		hold_rel(0, 3'h0);
		chk_rng(ticks, 2, 4);
		chk({vor, pulses}, {3'h5, 8'h01});
	endtask : t_spot

	task automatic t_repeat();
		ws(6'h01, 8'h01, 8'h01, 8'h28, 8'h01, 8'h00, 3'h2, 8'h01);
		start(32'h0001_0001);
		hold_rel(1200, 3'h0);
		chk_rng(pulses, 2, 20);
		start(32'h0001_0001);
		hold_rel(20, 3'h0);
		chk(pulses, 32'h0000_0001);
	endtask : t_repeat

	task automatic t_chain();
		ws(6'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 3'h1, 8'h02);
		ws(6'h03, 8'h02, 8'h02, 8'h32, 8'h02, 8'h00, 3'h2, 8'h00);
		start(32'h0001_0002);
		wait_state(4'hB);
		chk({rd[13:8], rd[6:4]}, {6'h03, 3'h3});
		hold_rel(0, 3'h0);
		chk({valve_out, vor}, {3'h0, 3'h3});
	endtask : t_chain

	task automatic t_slope();
		ws(6'h07, 8'h01, 8'h02, 8'h0A, 8'h00, 8'h00, 3'h1, 8'h02);
		ws(6'h08, 8'h00, 8'h04, 8'h32, 8'h01, 8'h00, 3'h2, 8'h00);
		apb(1'b1, 12'h488, 32'h0004_0100, rd, er);
		start(32'h0001_0007);
		wait_state(4'hB);
		chk({rd[13:8], rd[6:4], level}, {6'h07, 3'h1, 8'h0A});
		repeat (140) @(posedge clk);
		chk({disp, valve_out}, {6'h08, 3'h3});
		chk_rng(level, 20, 30);
		hold_rel(0, 3'h0);
		chk({vor, pulses}, {3'h3, 8'h01});
	endtask : t_slope

	task automatic t_succ();
		ws(6'h04, 8'h01, 8'h01, 8'h1E, 8'h01, 8'h00, 3'h1, 8'h03);
		ws(6'h05, 8'h01, 8'h01, 8'h1E, 8'h01, 8'h00, 3'h2, 8'h00);
		start(32'h0001_0004);
		hold_rel(20, 3'h5);
		chk({flash, disp}, {1'b1, 6'h05});
		start(32'h0001_0004);
		hold_rel(20, 3'h0);
		chk({flash, disp}, {1'b0, 6'h04});
	endtask : t_succ

	task automatic t_seam();
		ws(6'h06, 8'h01, 8'h01, 8'h28, 8'h01, 8'h00, 3'h1, 8'h00);
		start(32'h0001_0106);
		hold_rel(800, 3'h0);
		chk(pulses, 32'h0000_0001);
		chk_rng(ticks, 15, 40);
		ws(6'h06, 8'h01, 8'h02, 8'h28, 8'h01, 8'h02, 3'h1, 8'h00);
		start(32'h0001_0106);
		hold_rel(800, 3'h0);
		chk_rng(pulses, 3, 20);
		start(32'h0001_0006);
		hold_rel(800, 3'h0);
		chk(pulses, 32'h0000_0001);
		chk_rng(ticks, 1, 3);
	endtask : t_seam
	// ==================================================
	// Sequence and watchdog
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_spot();
		t_repeat();
		t_chain();
		t_slope();
		t_succ();
		t_seam();
		report_and_stop();
	end

	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end
endmodule : wss_sequencer_tb
